/* File: logic/wlm_defs.vh */
/*
 Register indices, field positions, reset values and timing counts
 of the wake-up line manager.
 Assumes a 100 MHz pclk and an APB byte address of four times the index.
*/
`ifndef WLM_DEFS_VH
`define WLM_DEFS_VH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define WLM_IDX_STATUS   8'hf8
`define WLM_IDX_CTRL     8'hf9
`define WLM_IDX_MASK_H   8'hfa
`define WLM_IDX_MASK_L   8'hfb
`define WLM_IDX_EDGE_H   8'hfc
`define WLM_IDX_EDGE_L   8'hfd
`define WLM_IDX_PEND_H   8'hfe
`define WLM_IDX_PEND_L   8'hff

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define WLM_CTRL_WAKE    0
`define WLM_CTRL_SRC     1
`define WLM_CTRL_STOP    2
`define WLM_STAT_EXIT    0
`define WLM_STAT_INSTOP  1
`define WLM_RST_BYTE     8'h00
`define WLM_RST_LINES    16'h0000

// ----------------------------------------------------------------
// Timing: oscillator restart time in ns, and its cycle count
// ----------------------------------------------------------------
`define WLM_OSC_NS       10000
`define WLM_CLK_NS       10
`define WLM_OSC_CYC      ((`WLM_OSC_NS + `WLM_CLK_NS - 1) / `WLM_CLK_NS)

`endif

/* File: logic/wlm_wake_line_manager.v */
/*
 Wake-up line manager: sixteen edge-triggered wake-up lines with
 mask, polarity and pending bits, the shared interrupt channel source
 select, and the three-write STOP entry sequence with its exit.
 Assumes one 100 MHz clock, an APB master on the same clock, and
 interrupt/DMA acknowledge pulses from core logic on that clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "wlm_defs.vh"

module wlm_wake_line_manager (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [15:0] wake_line,
   input  wire        dedicated_ext_irq_pin,
   input  wire        irq_ack,
   output reg         shared_ext_irq_channel,
   output reg         shared_irq_rise,
   output reg         wake_event,
   output reg         stop_mode,
   output reg         stop_exit_flag
);

   // ----------------------------------------------------------------
   // Sequence states
   // ----------------------------------------------------------------
   localparam [2:0] SQ_IDLE = 3'd0;
   localparam [2:0] SQ_ONE  = 3'd1;
   localparam [2:0] SQ_ZERO = 3'd2;
   localparam [2:0] SQ_STOP = 3'd3;
   localparam [2:0] SQ_WAKE = 3'd4;
   localparam [2:0] SQ_BAD1 = 3'd5;
   localparam [2:0] SQ_BAD0 = 3'd6;
   localparam [31:0] OSC_CYC_W = `WLM_OSC_CYC;
   localparam [9:0]  OSC_CYC   = OSC_CYC_W[9:0];

   // Word-aligned match of an APB address against a register index
   function sel;
      input [11:0] a;
      input [7:0]  idx;
      begin
         sel = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
      end
   endfunction

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   reg [1:0]  ctrl_r;
   reg [15:0] mask_r;
   reg [15:0] edge_r;
   reg [15:0] pend_r;
   reg [15:0] pend_nxt;
   reg [15:0] sync1_r;
   reg [15:0] sync2_r;
   reg [15:0] prev_r;
   reg        ded1_r;
   reg        ded2_r;
   reg [2:0]  seq_r;
   reg [2:0]  seq_nxt;
   reg [9:0]  osc_cnt_r;
   reg [31:0] rd_nxt;
   reg        map_ok;

   wire [15:0] set_vec;
   wire [15:0] unmasked;
   wire        any_unmasked;
   wire        wake_src;
   wire        combined;
   wire        wr_done;
   wire        rd_acc;
   wire        ctrl_wr;
   wire        reg_write;
   wire        line_event;
   wire        seq_ok;
   wire        stop_bit;
   wire        pend_drop;

   // ----------------------------------------------------------------
   // APB handshake
   // ----------------------------------------------------------------
   // One wait state: pready rises in the second access cycle,
   // so read data can come straight from a flip-flop.
   assign rd_acc  = psel & penable & ~pready;
   assign wr_done = psel & penable & pready & pwrite;
   assign ctrl_wr = wr_done & sel(paddr, `WLM_IDX_CTRL);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= rd_acc;
         prdata  <= rd_acc ? rd_nxt : 32'h0000_0000;
         pslverr <= rd_acc & ~map_ok;
      end
   end

   // Read mux; unmapped words read zero and answer with pslverr
   always @* begin
      rd_nxt = 32'h0000_0000;
      map_ok = 1'b1;
      case (paddr)
         {2'b00, `WLM_IDX_STATUS, 2'b00}: begin
            rd_nxt[`WLM_STAT_EXIT]   = stop_exit_flag;
            rd_nxt[`WLM_STAT_INSTOP] = stop_mode;
         end
         {2'b00, `WLM_IDX_CTRL, 2'b00}: begin
            rd_nxt[`WLM_CTRL_WAKE] = ctrl_r[`WLM_CTRL_WAKE];
            rd_nxt[`WLM_CTRL_SRC]  = ctrl_r[`WLM_CTRL_SRC];
            rd_nxt[`WLM_CTRL_STOP] = stop_bit;
         end
         {2'b00, `WLM_IDX_MASK_H, 2'b00}: rd_nxt[7:0] = mask_r[15:8];
         {2'b00, `WLM_IDX_MASK_L, 2'b00}: rd_nxt[7:0] = mask_r[7:0];
         {2'b00, `WLM_IDX_EDGE_H, 2'b00}: rd_nxt[7:0] = edge_r[15:8];
         {2'b00, `WLM_IDX_EDGE_L, 2'b00}: rd_nxt[7:0] = edge_r[7:0];
         {2'b00, `WLM_IDX_PEND_H, 2'b00}: rd_nxt[7:0] = pend_r[15:8];
         {2'b00, `WLM_IDX_PEND_L, 2'b00}: rd_nxt[7:0] = pend_r[7:0];
         default: map_ok = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   // The STOP bit is not stored here: it is read from the sequencer.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 2'b00;
         mask_r <= `WLM_RST_LINES;
         edge_r <= `WLM_RST_LINES;
      end else begin
         if (ctrl_wr)
            ctrl_r <= pwdata[1:0];
         if (wr_done && sel(paddr, `WLM_IDX_MASK_H))
            mask_r[15:8] <= pwdata[7:0];
         if (wr_done && sel(paddr, `WLM_IDX_MASK_L))
            mask_r[7:0] <= pwdata[7:0];
         if (wr_done && sel(paddr, `WLM_IDX_EDGE_H))
            edge_r[15:8] <= pwdata[7:0];
         if (wr_done && sel(paddr, `WLM_IDX_EDGE_L))
            edge_r[7:0] <= pwdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Line synchronisers and edge detection
   // ----------------------------------------------------------------
   // Pins are asynchronous, so two flops precede any edge logic.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= `WLM_RST_LINES;
         sync2_r <= `WLM_RST_LINES;
         prev_r  <= `WLM_RST_LINES;
         ded1_r  <= 1'b0;
         ded2_r  <= 1'b0;
      end else begin
         sync1_r <= wake_line;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
         ded1_r  <= dedicated_ext_irq_pin;
         ded2_r  <= ded1_r;
      end
   end

   // Each line picks its own trigger edge
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_line
         assign set_vec[gi] = edge_r[gi] ?
            (sync2_r[gi] & ~prev_r[gi]) :
            (~sync2_r[gi] & prev_r[gi]);
      end
   endgenerate

   // ----------------------------------------------------------------
   // Pending bits
   // ----------------------------------------------------------------
   // Writes load the byte (1 sets, 0 clears); a same-cycle edge wins,
   // so a read-modify-write clear never loses a fresh event.
   always @* begin
      pend_nxt = pend_r | set_vec;
      if (wr_done && sel(paddr, `WLM_IDX_PEND_H))
         pend_nxt[15:8] = pwdata[7:0] | set_vec[15:8];
      if (wr_done && sel(paddr, `WLM_IDX_PEND_L))
         pend_nxt[7:0] = pwdata[7:0] | set_vec[7:0];
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pend_r <= `WLM_RST_LINES;
      else
         pend_r <= pend_nxt;
   end

   // ----------------------------------------------------------------
   // Shared channel and wake-up event
   // ----------------------------------------------------------------
   assign unmasked     = mask_r & pend_r;
   assign any_unmasked = |unmasked;
   // With SRC set, a write that clears an unmasked pending bit pulls the channel low
   // for one cycle, so a bit still pending gives a fresh rising edge.
   assign pend_drop    = |(mask_r & pend_r & ~pend_nxt);
   assign wake_src     = ctrl_r[`WLM_CTRL_WAKE] & any_unmasked;
   assign combined     = ctrl_r[`WLM_CTRL_SRC] ? (any_unmasked & ~pend_drop)
                                               : ded2_r;

   // The channel only latches a request on a rising edge, so the drop
   // after a clear lets a level that stays high raise a second request.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shared_ext_irq_channel <= 1'b0;
         shared_irq_rise        <= 1'b0;
         wake_event             <= 1'b0;
      end else begin
         shared_ext_irq_channel <= combined;
         shared_irq_rise        <= combined & ~shared_ext_irq_channel;
         wake_event             <= wake_src;
      end
   end

   // ----------------------------------------------------------------
   // STOP sequencer
   // ----------------------------------------------------------------
   // Every register write counts, including those made by an
   // acknowledged interrupt or DMA, so any of them breaks the chain.
   assign reg_write  = wr_done | irq_ack;
   assign line_event = |(mask_r & set_vec & ~pend_r);
   assign seq_ok     = pwdata[`WLM_CTRL_WAKE] & ~any_unmasked
                       & (|mask_r) & ~line_event & ~irq_ack;
   assign stop_bit   = (seq_r == SQ_ONE) | (seq_r == SQ_STOP);

   always @* begin
      seq_nxt = seq_r;
      case (seq_r)
         SQ_IDLE: begin
            if (ctrl_wr && pwdata[`WLM_CTRL_STOP] && !irq_ack)
               seq_nxt = SQ_ONE;
         end
         SQ_ONE: begin
            if (irq_ack || line_event)
               seq_nxt = SQ_BAD1;
            else if (ctrl_wr && !pwdata[`WLM_CTRL_STOP])
               seq_nxt = SQ_ZERO;
            else if (ctrl_wr)
               seq_nxt = SQ_ONE;
            else if (reg_write)
               seq_nxt = SQ_BAD1;
         end
         SQ_ZERO: begin
            if (irq_ack || line_event)
               seq_nxt = SQ_BAD0;
            else if (ctrl_wr && pwdata[`WLM_CTRL_STOP] && seq_ok)
               seq_nxt = SQ_STOP;
            else if (ctrl_wr)
               seq_nxt = SQ_IDLE;
            else if (reg_write)
               seq_nxt = SQ_BAD0;
         end
         // A broken triple still consumes its remaining writes, so its
         // closing 1 cannot start a new sequence and STOP reads 0.
         SQ_BAD1: begin
            if (ctrl_wr && !pwdata[`WLM_CTRL_STOP])
               seq_nxt = SQ_BAD0;
            else if (ctrl_wr)
               seq_nxt = SQ_IDLE;
         end
         SQ_BAD0: begin
            if (ctrl_wr)
               seq_nxt = SQ_IDLE;
         end
         SQ_STOP: begin
            if (wake_src)
               seq_nxt = SQ_WAKE;
         end
         SQ_WAKE: begin
            if (osc_cnt_r == 10'd0)
               seq_nxt = SQ_IDLE;
         end
         default: seq_nxt = SQ_IDLE;
      endcase
   end

   // Oscillator restart delay runs from the wake event
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_r     <= SQ_IDLE;
         osc_cnt_r <= 10'd0;
         stop_mode <= 1'b0;
      end else begin
         seq_r <= seq_nxt;
         if (seq_r == SQ_STOP)
            osc_cnt_r <= OSC_CYC - 10'd1;
         else if (osc_cnt_r != 10'd0)
            osc_cnt_r <= osc_cnt_r - 10'd1;
         stop_mode <= (seq_nxt == SQ_STOP) | (seq_nxt == SQ_WAKE);
      end
   end

   // ----------------------------------------------------------------
   // Stop-exit flag
   // ----------------------------------------------------------------
   // Set by a real exit and held until software writes 0; the set
   // beats a clear in the same cycle. An acknowledge that filters
   // the entry request clears it.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         stop_exit_flag <= 1'b0;
      else if (seq_r == SQ_WAKE && osc_cnt_r == 10'd0)
         stop_exit_flag <= 1'b1;
      else if (irq_ack && (seq_r == SQ_ONE || seq_r == SQ_ZERO))
         stop_exit_flag <= 1'b0;
      else if (wr_done && sel(paddr, `WLM_IDX_STATUS) &&
               !pwdata[`WLM_STAT_EXIT])
         stop_exit_flag <= 1'b0;
   end

endmodule

`default_nettype wire

/* File: tb/wlm_checker.sv */
/*
 Port checker for the wake-up line manager, bound into every instance.
 Assumes one pclk domain with asynchronous active-low presetn.
*/
`timescale 1ns/1ns
`default_nettype none
module wlm_checker (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        irq_ack,
   input wire        shared_ext_irq_channel,
   input wire        shared_irq_rise,
   input wire        wake_event,
   input wire        stop_mode,
   input wire        stop_exit_flag
);
   logic [11:0] stop_cnt_r;
   // Cycles spent in STOP with a wake source present; a slack of ten cycles
   // covers the pipeline between pending bit and wake source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         stop_cnt_r <= 12'h000;
      else if (stop_mode && wake_event)
         stop_cnt_r <= stop_cnt_r + 12'h001;
      else
         stop_cnt_r <= 12'h000;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_in_access_a: assert property (pready |-> psel && penable && $past(psel && penable))
      else $error("pready outside access phase");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   idle_data_a: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero outside answer");
   stop_cause_a: assert property ($rose(stop_mode) |->
      $past(pready && pwrite && paddr == 12'h3e4 && pwdata[2])) else $error("stop without write");
   stop_hold_a: assert property ($rose(stop_mode) |=> stop_mode [*8])
      else $error("stop left too soon");
   exit_with_fall_a: assert property ($rose(stop_exit_flag) |-> $fell(stop_mode))
      else $error("exit flag without stop exit");
   exit_sticky_a: assert property (stop_exit_flag && !irq_ack &&
      !(pready && pwrite && paddr == 12'h3e0) |=> stop_exit_flag) else $error("exit flag lost");
   restart_min_a: assert property ($fell(stop_mode) |-> $past(stop_cnt_r) >= 12'h3de)
      else $error("oscillator delay too short");
   restart_max_a: assert property (stop_cnt_r < 12'h3f2)
      else $error("oscillator delay too long");
   rise_pulse_a: assert property ($rose(shared_ext_irq_channel) |-> shared_irq_rise)
      else $error("channel rise not flagged");
endmodule
bind wlm_wake_line_manager wlm_checker i_wlm_checker (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_ack(irq_ack),
   .shared_ext_irq_channel(shared_ext_irq_channel), .shared_irq_rise(shared_irq_rise),
   .wake_event(wake_event), .stop_mode(stop_mode), .stop_exit_flag(stop_exit_flag));
`default_nettype wire

/* File: tb/wlm_line_model.sv */
/*
 External pins model: wake-up lines and the dedicated interrupt pin.
 Assumes the bench holds each requested level for several cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module wlm_line_model (
   input  wire logic        pclk,
   input  wire logic [15:0] lvl_req,
   input  wire logic        pin_req,
   output var  logic [15:0] wake_line,
   output var  logic        dedicated_ext_irq_pin
);
   // Pins idle low from time zero so the synchronisers never see X
   initial begin
      wake_line = 16'h0000;
      dedicated_ext_irq_pin = 1'b0;
   end
   // Levels follow requests one cycle late, like a board trace
   always @(posedge pclk) begin
      wake_line <= lvl_req;
      dedicated_ext_irq_pin <= pin_req;
   end
endmodule
`default_nettype wire

/* File: tb/tb_wakeup_interrupt_line_manager.sv */
/*
 Self-checking bench for the wake-up line manager.
 Assumes the checker is bound and the line model drives the pins.
*/
`timescale 1ns/1ns
`default_nettype none
`include "wlm_defs.vh"
module tb_wakeup_interrupt_line_manager;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, irq_ack = 1'b0, pin_req = 1'b0, rd_err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd_v;
   logic [15:0] lvl_req = 16'h0000, wake_line;
   logic        pready, pslverr, dedicated_ext_irq_pin, shared_ext_irq_channel;
   logic        shared_irq_rise, wake_event, stop_mode, stop_exit_flag;
   int          err_total = 0, checks_done = 0, rise_cnt = 0, n, r0;
   // ----------------------------------------------------------------
   // Clock, instances and monitors
   // ----------------------------------------------------------------
   always #5 pclk = ~pclk;
   always @(posedge pclk) if (shared_irq_rise === 1'b1) rise_cnt <= rise_cnt + 1;
   wlm_line_model i_wlm_line_model (.pclk(pclk), .lvl_req(lvl_req), .pin_req(pin_req),
      .wake_line(wake_line), .dedicated_ext_irq_pin(dedicated_ext_irq_pin));
   wlm_wake_line_manager i_wlm_wake_line_manager (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_line(wake_line),
      .dedicated_ext_irq_pin(dedicated_ext_irq_pin), .irq_ack(irq_ack),
      .shared_ext_irq_channel(shared_ext_irq_channel), .shared_irq_rise(shared_irq_rise),
      .wake_event(wake_event), .stop_mode(stop_mode), .stop_exit_flag(stop_exit_flag));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge pclk);
   endtask
   // One APB transfer; waits for pready, never a fixed count
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_v = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Software preparation before a STOP attempt
   task automatic prep(input logic [7:0] m);
      lvl_req <= 16'h0000;
      wt(8);
      apb(1'b1, `WLM_IDX_MASK_L, {24'h0, m});
      apb(1'b1, `WLM_IDX_EDGE_L, 32'h1);
      apb(1'b1, `WLM_IDX_PEND_H, 32'h0);
      apb(1'b1, `WLM_IDX_PEND_L, 32'h0);
      apb(1'b1, `WLM_IDX_STATUS, 32'h0);
      apb(1'b1, `WLM_IDX_CTRL, 32'h1);
   endtask
   // Three-write sequence; f selects a disturbance before the third write (1-3) or a 0 wake bit in all three writes (4)
   task automatic stop_seq(input int f);
      logic [31:0] w;
      w = (f == 4) ? 32'h0 : 32'h1;
      apb(1'b1, `WLM_IDX_CTRL, w | 32'h4);
      apb(1'b1, `WLM_IDX_CTRL, w);
      if (f == 1) begin
         irq_ack <= 1'b1;
         @(posedge pclk);
         irq_ack <= 1'b0;
         @(posedge pclk);
      end
      if (f == 2) begin
         lvl_req <= 16'h0001;
         wt(8);
      end
      if (f == 3) apb(1'b1, `WLM_IDX_MASK_L, 32'h1);
      apb(1'b1, `WLM_IDX_CTRL, w | 32'h4);
      wt(3);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      for (int i = 8'hf8; i <= 8'hff; i++) begin
         apb(1'b0, i[7:0], 32'h0);
         chk(rd_v, `WLM_RST_BYTE);
      end
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, rd_err}, 32'h1);
      chk(rd_v, 32'h0);
   endtask
   // Acknowledge, line event, stray write, no wake mode, no mask
   task automatic t_abort;
      for (int f = 1; f <= 5; f++) begin
         prep((f == 5) ? 8'h00 : 8'h01);
         stop_seq(f);
         chk(stop_mode, 1'b0);
         chk(stop_exit_flag, 1'b0);
         apb(1'b0, `WLM_IDX_CTRL, 32'h0);
         chk(rd_v & 32'h4, 32'h0);
      end
   endtask
   task automatic t_stop_ok;
      prep(8'h01);
      stop_seq(0);
      chk(stop_mode, 1'b1);
      apb(1'b0, `WLM_IDX_CTRL, 32'h0);
      chk(rd_v, 32'h5);
      lvl_req <= 16'h0001;
      n = 0;
      while (stop_mode !== 1'b0 && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      chk(n > `WLM_OSC_CYC && n < 2000, 1'b1);
      chk(stop_exit_flag, 1'b1);
      apb(1'b0, `WLM_IDX_CTRL, 32'h0);
      chk(rd_v & 32'h4, 32'h0);
      apb(1'b0, `WLM_IDX_STATUS, 32'h0);
      chk(rd_v, 32'h1);
      apb(1'b1, `WLM_IDX_PEND_L, 32'h0);
      apb(1'b0, `WLM_IDX_PEND_L, 32'h0);
      chk(rd_v, 32'h0);
      apb(1'b1, `WLM_IDX_STATUS, 32'h0);
      chk(stop_exit_flag, 1'b0);
   endtask
   task automatic t_irq_mode;
      prep(8'h03);
      apb(1'b1, `WLM_IDX_CTRL, 32'h2);
      lvl_req <= 16'h0002;
      wt(8);
      apb(1'b0, `WLM_IDX_PEND_L, 32'h0);
      chk(rd_v, 32'h0);
      lvl_req <= 16'h0003;
      wt(8);
      chk(shared_ext_irq_channel, 1'b1);
      lvl_req <= 16'h0001;
      wt(8);
      r0 = rise_cnt;
      apb(1'b1, `WLM_IDX_PEND_L, 32'h2);
      wt(6);
      chk(rise_cnt - r0, 32'h1);
      apb(1'b0, `WLM_IDX_PEND_L, 32'h0);
      chk(rd_v, 32'h2);
      apb(1'b1, `WLM_IDX_CTRL, 32'h0);
      wt(4);
      chk({shared_ext_irq_channel, wake_event}, 2'b00);
      pin_req <= 1'b1;
      wt(8);
      chk(shared_ext_irq_channel, 1'b1);
      pin_req <= 1'b0;
      apb(1'b1, `WLM_IDX_CTRL, 32'h1);
      wt(4);
      chk({shared_ext_irq_channel, wake_event}, 2'b01);
      apb(1'b1, `WLM_IDX_CTRL, 32'h3);
      wt(4);
      chk({shared_ext_irq_channel, wake_event}, 2'b11);
      apb(1'b1, `WLM_IDX_PEND_L, 32'h0);
      wt(4);
      chk({shared_ext_irq_channel, wake_event}, 2'b00);
   endtask
   // ----------------------------------------------------------------
   // Verdict, watchdog and main sequence
   // ----------------------------------------------------------------
   task automatic print_verdict;
      if (err_total == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Whole run needs about 1500 cycles; allow about thirteen times that
   initial begin
      #200000;
      err_total++;
      print_verdict();
   end
   initial begin
      wt(5);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_abort();
      t_stop_ok();
      t_irq_mode();
      print_verdict();
   end
endmodule
`default_nettype wire
